// [src/sst_sequencer.sv]
// selftest sequencer: power-on chain, jumper-selected tests, led, apb
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - power-on tests cpu, rom, bus chip, rams
// - then both drives, spindle speed, ecc chip
// - host diagnostic command reruns power-on sequence
// - run jumper selects test from wheel+bank
// - repeat selected test while jumper fitted
// - jumper removed: finish, power-on, accept host
// - blink led once at each jumper-selected test start
// - pass blinks led five times
// - fail lights led five seconds, then off or straight into a lamp check or power-on
// - start: led on 4 s, off 0.5 s
// - led lit throughout the running test
// - after ram test only ram test allowed
// - other tests selectable in any order
// - ram test writes all patterns, both rams
// - rom test checks program memory checksum
// - tests 2,3 verify chip register writes
// - floppy seek checks track-zero indicator
// - hard seek exercises cylinder zero, track 35
// - floppy speed skipped without medium
// - hard write-verify reserved cylinder, ecc
// - tests 10,11 crc-verify data area
// - test 13 checks hard controller registers
module sst_sequencer
  import sst_pkg::*;
#(
  parameter longint LAMP_ON_CYC  = SST_LAMP_ON_CYC,
  parameter longint LAMP_OFF_CYC = SST_LAMP_OFF_CYC,
  parameter longint BLINK_CYC    = SST_BLINK_CYC,
  parameter longint FAIL_CYC     = SST_FAIL_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  // service pins
  input  wire logic        test_run_jumper_n,
  input  wire logic        test_bank_jumper,
  input  wire logic [2:0]  address_thumbwheel,
  // test engine
  output var  sst_req_t    test_req,
  input  wire sst_rsp_t    test_rsp,
  // front panel and host side
  output var  logic        led_on,
  output var  logic        host_ready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [SST_TMR_W-1:0] TMR_ZERO = '0;

  logic [4:0]           pin_s1_reg;
  logic [4:0]           pin_s2_reg;
  logic [4:0]           pin_s3_reg;
  logic [4:0]           pin_reg;
  sst_state_t           state_reg;
  sst_state_t           state_next;
  logic [SST_TMR_W-1:0] tmr_reg;
  logic [2:0]           blink_reg;
  logic [3:0]           step_reg;
  logic                 in_select_reg;
  logic [3:0]           sel_test_reg;
  logic                 ram_spent_reg;
  logic                 diag_pend_reg;
  logic                 last_pass_reg;
  logic                 last_fail_reg;
  logic [SST_ID_W-1:0]  fail_id_reg;
  logic                 pready_reg;
  logic [31:0]          prdata_reg;
  logic                 pslverr_reg;
  sst_req_t             req_reg;
  logic                 led_reg;
  logic                 ready_reg;
  logic                 run_fitted;
  logic [3:0]           sel_now;
  logic                 tmr_done;
  logic                 apb_access;
  logic                 apb_commit;
  logic                 diag_write;
  logic                 refused;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; a new level counts only when stages two and three
  // agree, so one-cycle glitches from a moving wheel are dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_reg <= 5'h1F;
      pin_s2_reg <= 5'h1F;
      pin_s3_reg <= 5'h1F;
    end else begin
      pin_s1_reg <= {test_run_jumper_n, test_bank_jumper, address_thumbwheel};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // filtered pin levels; jumper reads absent until proven fitted
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_reg <= 5'h1F;
    end else if (pin_s2_reg == pin_s3_reg) begin
      pin_reg <= pin_s3_reg;
    end
  end

  assign sel_now    = pin_reg[3:0];
  assign run_fitted = ~pin_reg[4];  // fitted pulls the pin low

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign tmr_done = (tmr_reg == TMR_ZERO);
  // non-ram test refused after ram test
  assign refused  = ram_spent_reg && (sel_test_reg != SST_TEST_RAM[3:0]);

  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SST_POST_START: state_next = SST_POST_WAIT;
      // stop the chain on first failure
      SST_POST_WAIT: begin
        if (test_rsp.done && !test_rsp.pass) begin
          state_next = SST_FAIL;
        end else if (test_rsp.done && step_reg == SST_LAST_STEP) begin
          state_next = SST_PASS_ON;
        end else if (test_rsp.done) begin
          state_next = SST_POST_START;
        end
      end
      SST_IDLE: begin
        if (run_fitted) begin
          state_next = SST_LAMP_ON;
        end else if (diag_pend_reg) begin
          state_next = SST_POST_START;
        end
      end
      SST_LAMP_ON:  if (tmr_done) state_next = SST_LAMP_OFF;
      SST_LAMP_OFF: if (tmr_done) state_next = SST_RUN_START;
      SST_RUN_START: state_next = refused ? SST_FAIL : SST_RUN_WAIT;
      SST_RUN_WAIT: begin
        if (test_rsp.done) begin
          state_next = test_rsp.pass ? SST_PASS_ON : SST_FAIL;
        end
      end
      SST_PASS_ON: if (tmr_done) state_next = SST_PASS_OFF;
      SST_PASS_OFF: begin
        if (tmr_done && blink_reg != SST_PASS_BLINKS) begin
          state_next = SST_PASS_ON;
        end else if (tmr_done) begin
          state_next = SST_IDLE;
        end
      end
      SST_FAIL: if (tmr_done) state_next = SST_IDLE;
    endcase
    // repeat while the jumper stays fitted
    if (state_next == SST_IDLE && in_select_reg) begin
      state_next = run_fitted ? SST_LAMP_ON : SST_POST_START;
    end
  end

  // state and phase timer; the timer is loaded as a phase is entered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= SST_POST_START;
      tmr_reg   <= TMR_ZERO;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || tmr_done) begin
        unique case (state_next)
          // 4 s lit, 0.5 s dark
          SST_LAMP_ON:  tmr_reg <= SST_TMR_W'(LAMP_ON_CYC - 1);
          SST_LAMP_OFF: tmr_reg <= SST_TMR_W'(LAMP_OFF_CYC - 1);
          SST_PASS_ON:  tmr_reg <= SST_TMR_W'(BLINK_CYC - 1);
          SST_PASS_OFF: tmr_reg <= SST_TMR_W'(BLINK_CYC - 1);
          SST_FAIL:     tmr_reg <= SST_TMR_W'(FAIL_CYC - 1);
          default:      tmr_reg <= TMR_ZERO;
        endcase
      end else begin
        tmr_reg <= tmr_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      blink_reg <= 3'h0;
    end else if (state_reg != SST_PASS_ON && state_next == SST_PASS_ON) begin
      blink_reg <= (state_reg == SST_PASS_OFF) ? blink_reg + 3'h1 : 3'h1;
    end
  end

  // power-on step index walks the full chain
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      step_reg <= 4'h0;
    end else if (state_reg != SST_POST_WAIT && state_next == SST_POST_START) begin
      step_reg <= 4'h0;
    end else if (state_reg == SST_POST_WAIT && state_next == SST_POST_START) begin
      step_reg <= step_reg + 4'h1;
    end
  end

  // selection is latched at each lamp check so a moving wheel
  // cannot change the test between its indication and its run
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_select_reg <= 1'b0;
      sel_test_reg  <= 4'h0;
    end else if (state_next == SST_LAMP_ON && state_reg != SST_LAMP_ON) begin
      in_select_reg <= 1'b1;
      sel_test_reg  <= sel_now;
    end else if (state_next == SST_POST_START) begin
      in_select_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // test engine request
  // ----------------------------------------------------------------
  // ram test runs over both rams
  // bus and floppy chip register tests
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_reg <= '0;
    end else if (state_reg == SST_POST_START) begin
      req_reg.start <= 1'b1;
      req_reg.id    <= SST_POST_IDS[step_reg];
    end else if (state_reg == SST_RUN_START && !refused) begin
      req_reg.start <= 1'b1;
      req_reg.id    <= {1'b0, sel_test_reg};
    end else begin
      req_reg.start <= 1'b0;
    end
  end

  // ram test spends loaded parameters
  // only a reset, the power cycle, brings them back
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ram_spent_reg <= 1'b0;
    end else if (state_reg == SST_RUN_START && sel_test_reg == SST_TEST_RAM[3:0]) begin
      ram_spent_reg <= 1'b1;
    end
  end

  // last outcome and the id that failed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_pass_reg <= 1'b0;
      last_fail_reg <= 1'b0;
      fail_id_reg   <= '0;
    end else if (state_reg != SST_FAIL && state_next == SST_FAIL) begin
      last_pass_reg <= 1'b0;
      last_fail_reg <= 1'b1;
      fail_id_reg   <= (state_reg == SST_POST_WAIT) ? SST_POST_IDS[step_reg]
                                                    : {1'b0, sel_test_reg};
    end else if (state_reg != SST_PASS_ON && state_next == SST_PASS_ON
                 && (state_reg == SST_POST_WAIT || state_reg == SST_RUN_WAIT)) begin
      last_pass_reg <= 1'b1;
      last_fail_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // led and host readiness
  // ----------------------------------------------------------------
  // lamp check blink opens each jumper-selected test
  // fail shown as five seconds lit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      led_reg <= 1'b0;
    end else begin
      unique case (state_next)
        SST_LAMP_ON, SST_RUN_START, SST_RUN_WAIT: led_reg <= 1'b1;
        SST_POST_START, SST_POST_WAIT:            led_reg <= 1'b1;
        SST_PASS_ON, SST_FAIL:                    led_reg <= 1'b1;
        default:                                  led_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == SST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  assign apb_access = psel && penable;
  assign apb_commit = apb_access && pready_reg;
  assign diag_write = apb_commit && pwrite && (paddr == SST_CTRL_OFS)
                      && pwdata[SST_CTRL_DIAG_BIT];

  // answer: data and error are set up together with pready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (apb_access && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !(paddr == SST_CTRL_OFS || paddr == SST_STATUS_OFS
                       || paddr == SST_RESULT_OFS);
      prdata_reg  <= 32'h0000_0000;
      if (!pwrite && paddr == SST_STATUS_OFS) begin
        prdata_reg <= {20'h00000, sel_test_reg, state_reg, ram_spent_reg,
                       last_fail_reg, last_pass_reg, ready_reg};
      end else if (!pwrite && paddr == SST_RESULT_OFS) begin
        prdata_reg <= {27'h0000000, fail_id_reg};
      end else if (!pwrite && paddr == SST_CTRL_OFS) begin
        prdata_reg <= {31'h00000000, diag_pend_reg};
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // pending diagnostic command
  // taken only while ready; a new command wins over the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      diag_pend_reg <= 1'b0;
    end else if (diag_write && ready_reg) begin
      diag_pend_reg <= 1'b1;
    end else if (state_next == SST_POST_START) begin
      diag_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready     = pready_reg;
  assign prdata     = prdata_reg;
  assign pslverr    = pslverr_reg;
  assign test_req   = req_reg;
  assign led_on     = led_reg;
  assign host_ready = ready_reg;

endmodule : sst_sequencer

`default_nettype wire

// [src/sst_pkg.sv]
// shared constants and types for the selftest sequencer
package sst_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam longint SST_CLK_HZ      = 20000000;
  localparam longint SST_LAMP_ON_MS  = 4000;  // start indication, lit
  localparam longint SST_LAMP_OFF_MS = 500;   // start indication, dark
  localparam longint SST_BLINK_MS    = 500;   // each half of a pass blink
  localparam longint SST_FAIL_MS     = 5000;  // fail indication, lit
  // longest time of each phase, rounded down to whole cycles
  localparam longint SST_LAMP_ON_CYC  = SST_LAMP_ON_MS * SST_CLK_HZ / 1000;
  localparam longint SST_LAMP_OFF_CYC = SST_LAMP_OFF_MS * SST_CLK_HZ / 1000;
  localparam longint SST_BLINK_CYC    = SST_BLINK_MS * SST_CLK_HZ / 1000;
  localparam longint SST_FAIL_CYC     = SST_FAIL_MS * SST_CLK_HZ / 1000;
  localparam int     SST_TMR_W        = 27;
  localparam logic [2:0] SST_PASS_BLINKS = 3'h5;

  // ----------------------------------------------------------------
  // test identifiers on the engine port
  // ----------------------------------------------------------------
  localparam int SST_ID_W = 5;
  localparam logic [SST_ID_W-1:0] SST_TEST_RAM = 5'h00;
  localparam int SST_POST_STEPS = 9;
  // cpu, rom, host bus chip, cpu ram, buffer ram, drive a rw,
  // drive b rw, spindle speed, error-correction chip
  localparam logic [SST_ID_W-1:0] SST_POST_IDS [0:SST_POST_STEPS-1] = '{
    5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18};
  localparam logic [3:0] SST_LAST_STEP = 4'h8;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SST_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SST_STATUS_OFS = 8'h04;
  localparam logic [7:0] SST_RESULT_OFS = 8'h08;
  localparam int SST_CTRL_DIAG_BIT = 0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                start;  // one-cycle start pulse
    logic [SST_ID_W-1:0] id;     // test or power-on step to run
  } sst_req_t;

  typedef struct packed {
    logic done;  // one-cycle completion pulse
    logic pass;  // valid with done
  } sst_rsp_t;

  typedef enum logic [3:0] {
    SST_POST_START, SST_POST_WAIT, SST_IDLE, SST_LAMP_ON, SST_LAMP_OFF,
    SST_RUN_START, SST_RUN_WAIT, SST_PASS_ON, SST_PASS_OFF, SST_FAIL
  } sst_state_t;

endpackage : sst_pkg

// [tb/sst_eng_model.sv]
// behavioural test engine that answers the sequencer's start pulses
`timescale 1ns/10ps
`default_nettype none
module sst_eng_model
  import sst_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // sequencer side
  input  wire sst_req_t   test_req,
  output var  sst_rsp_t   test_rsp,
  // scenario control: which id is made to fail
  input  wire logic       fail_en,
  input  wire logic [4:0] fail_id
);
  logic       busy;
  logic [3:0] cnt;
  logic [4:0] id;

  // latency depends on the id so that quick and slow answers both occur
  always_ff @(posedge ref_clk) begin
    test_rsp <= '0;
    if (rst) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
      id   <= 5'h00;
    end else if (test_req.start) begin
      busy <= 1'b1;
      cnt  <= 4'h2 + {1'b0, test_req.id[1:0], 1'b0};
      id   <= test_req.id;
    end else if (busy && cnt == 4'h0) begin
      busy     <= 1'b0;
      test_rsp <= '{done: 1'b1, pass: !(fail_en && id == fail_id)};
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : sst_eng_model
`default_nettype wire

// [tb/sst_chk.sv]
// port-level assertion checker for the selftest sequencer
`timescale 1ns/10ps
`default_nettype none
module sst_chk
  import sst_pkg::*;
#(
  parameter longint LAMP_ON_CYC  = SST_LAMP_ON_CYC,
  parameter longint LAMP_OFF_CYC = SST_LAMP_OFF_CYC
) (
  // clock and reset
  input wire logic     ref_clk,
  input wire logic     rst,
  // apb handshake
  input wire logic     psel,
  input wire logic     penable,
  input wire logic     pready,
  // pins, engine and panel
  input wire logic     test_run_jumper_n,
  input wire sst_req_t test_req,
  input wire sst_rsp_t test_rsp,
  input wire logic     led_on,
  input wire logic     host_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // indication sequences
  // ----------------------------------------------------------------
  // counts fit the bench build only (blink 3, fail 10); repeats cannot take params
  sequence s_blink;
    led_on [*3] ##1 !led_on [*3];
  endsequence
  sequence s_fail_lit;
    led_on [*8] ##1 led_on [*2];
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_APB_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait");
  AST_APB_PHASE: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("apb answer outside access phase");
  AST_START_PULSE: assert property (test_req.start |=> !test_req.start)
    else $error("start longer than one cycle");
  AST_POST_FIRST: assert property ($fell(rst) |=> test_req.start && test_req.id == SST_POST_IDS[0])
    else $error("power-on chain did not start with first step");
  AST_POST_NEXT: assert property (test_rsp.done && test_rsp.pass &&
      test_req.id inside {[5'h10:5'h17]} |-> ##2 test_req.start &&
      test_req.id == $past(test_req.id) + 5'h01)
    else $error("power-on step out of order");
  AST_LAMP: assert property (test_req.start && test_req.id < 5'h10 |->
      $past(led_on) && !$past(led_on, 2) && !$past(led_on, LAMP_OFF_CYC + 1) &&
      $past(led_on, LAMP_OFF_CYC + 2) && $past(led_on, LAMP_OFF_CYC + LAMP_ON_CYC + 1))
    else $error("lamp check timing wrong");
  AST_LED_RUN: assert property (test_req.start && test_req.id < 5'h10 |-> led_on ##1 led_on)
    else $error("led dark while test runs");
  AST_PASS: assert property (test_rsp.done && test_rsp.pass && test_req.id < 5'h10 |=>
      s_blink ##1 s_blink ##1 s_blink ##1 s_blink ##1 s_blink)
    else $error("pass blinks wrong");
  // after the lit phase the led goes dark unless a lamp check or power-on follows at once
  AST_FAIL: assert property (test_rsp.done && !test_rsp.pass && test_req.id < 5'h10 |=>
      s_fail_lit ##1 ((!led_on || !test_run_jumper_n) or (1'b1 ##1 test_req.start)))
    else $error("fail indication wrong");
  AST_IDLE_QUIET: assert property (host_ready |-> !test_req.start)
    else $error("test started while host ready");
endmodule : sst_chk
`default_nettype wire

// [tb/tb_top.sv]
// self-checking testbench for the selftest sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sst_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        jmp_n, bank, fail_en, led_on, host_ready, err;
  logic [2:0]  wheel;
  logic [4:0]  fail_id, last_id;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  sst_req_t    test_req;
  sst_rsp_t    test_rsp;
  int          num_errors, checks, n_start, cyc;

  sst_sequencer #(.LAMP_ON_CYC(8), .LAMP_OFF_CYC(4), .BLINK_CYC(3), .FAIL_CYC(10)) dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .test_run_jumper_n(jmp_n), .test_bank_jumper(bank), .address_thumbwheel(wheel),
    .test_req(test_req), .test_rsp(test_rsp), .led_on(led_on), .host_ready(host_ready));
  sst_eng_model u_eng (.ref_clk(ref_clk), .rst(rst), .test_req(test_req),
    .test_rsp(test_rsp), .fail_en(fail_en), .fail_id(fail_id));

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // start monitor and hang guard; the ceiling is far above the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (test_req.start === 1'b1) begin
      n_start++;
      last_id = test_req.id;
    end
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // pready sampled high ends this wait; there is no local limit, only the bench timeout
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_ready();
    repeat (3) @(posedge ref_clk);
    while (host_ready !== 1'b1) @(posedge ref_clk);
  endtask : wait_ready

  task automatic wait_start(int k);
    while (n_start < k) @(posedge ref_clk);
  endtask : wait_start

  task automatic t_post();
    wait_ready();
    chk("post steps", 32'(n_start), 32'd9);
    chk("post last id", 32'(last_id), 32'(SST_POST_IDS[8]));
    apb(1'b0, SST_STATUS_OFS, 32'h0);
    chk("status ready pass", rd & 32'h7, 32'h3);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("power-on test done");
  endtask : t_post

  // diagnostic rerun: once with a failing step, once clean
  task automatic t_diag();
    int s0;
    s0 = n_start;
    fail_en <= 1'b1;
    fail_id <= 5'h12;
    apb(1'b1, SST_CTRL_OFS, 32'h1);
    wait_ready();
    chk("diag fail steps", 32'(n_start - s0), 32'd3);
    apb(1'b0, SST_RESULT_OFS, 32'h0);
    chk("failed id", rd & 32'h1F, 32'h12);
    fail_en <= 1'b0;
    s0 = n_start;
    apb(1'b1, SST_CTRL_OFS, 32'h1);
    wait_ready();
    chk("diag steps", 32'(n_start - s0), 32'd9);
    $display("diagnostic test done");
  endtask : t_diag

  // jumper-selected test; a refused one must never start
  task automatic t_sel(logic [2:0] w, logic b, logic ok);
    int s0;
    s0 = n_start;
    wheel <= w;
    bank  <= b;
    jmp_n <= 1'b0;
    if (ok) begin
      wait_start(s0 + 1);
      chk("selected id", 32'(last_id), {28'h0, b, w});
      wait_start(s0 + 2);
      chk("repeat id", 32'(last_id), {28'h0, b, w});
    end else begin
      repeat (150) @(posedge ref_clk);
      chk("refused starts", 32'(n_start - s0), 32'd0);
      apb(1'b0, SST_STATUS_OFS, 32'h0);
      chk("refused fail", rd & 32'h4, 32'h4);
    end
    jmp_n <= 1'b1;
    wait_ready();
    chk("post after jumper", 32'(last_id), 32'(SST_POST_IDS[8]));
    $display("selected test %0d done", {b, w});
  endtask : t_sel

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {jmp_n, bank, wheel, fail_en, fail_id} = {1'b1, 10'h0};
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_post();
    t_diag();
    // any order before the ram test
    t_sel(3'h5, 1'b1, 1'b1);
    fail_en <= 1'b1;
    fail_id <= 5'h02;
    t_sel(3'h2, 1'b0, 1'b1);
    fail_en <= 1'b0;
    t_sel(3'h0, 1'b0, 1'b1);
    t_sel(3'h3, 1'b0, 1'b0);
    t_sel(3'h0, 1'b0, 1'b1);
    wrap_up();
  end
endmodule : tb_top

bind sst_sequencer sst_chk #(.LAMP_ON_CYC(LAMP_ON_CYC), .LAMP_OFF_CYC(LAMP_OFF_CYC)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .test_run_jumper_n(test_run_jumper_n), .test_req(test_req), .test_rsp(test_rsp),
  .led_on(led_on), .host_ready(host_ready));
`default_nettype wire
